// [design/spu_pkg.sv]
// ==========================================================================
// Shared constants for the serial port
// ==========================================================================
package spu_pkg;

  // Mode field codes, {mode_select_hi, mode_select_lo}
  localparam logic [1:0] SPU_MODE_SHIFT = 2'h0;
  localparam logic [1:0] SPU_MODE_UART8 = 2'h1;
  localparam logic [1:0] SPU_MODE_UART9_FIXED = 2'h2;
  localparam logic [1:0] SPU_MODE_UART9_VAR = 2'h3;

  // Baud generator: last prescaler count (divide by 6) and counter top
  localparam logic [2:0] SPU_BRG_PRESCALE_LAST = 3'h5;
  localparam logic [7:0] SPU_BRG_TOP = 8'hff;

  // Shift mode half-bit lengths: fixed rate is 3 clocks per half (clk/6),
  // variable rate is 8 baud generator overflows per half (16 per bit)
  localparam logic [2:0] SPU_M0_FIXED_HALF_LAST = 3'h2;
  localparam logic [2:0] SPU_M0_VAR_HALF_LAST = 3'h7;
  localparam logic [3:0] SPU_M0_LAST_BIT = 4'h7;

  // Asynchronous oversampling: 16 ticks per bit, start checked at mid-bit
  localparam logic [3:0] SPU_OVS_MID = 4'h7;
  localparam logic [3:0] SPU_OVS_LAST = 4'hf;

  // Async transmit last bit indices, counted from the start bit (0)
  localparam logic [3:0] SPU_TX_LAST_M1 = 4'h9;
  localparam logic [3:0] SPU_TX_LAST_M23 = 4'ha;

  // Async receive sample indices after the start bit (0 = D0)
  localparam logic [3:0] SPU_RX_NINTH_IDX = 4'h8;
  localparam logic [3:0] SPU_RX_STOP23_IDX = 4'h9;

  // Reset values
  localparam logic [7:0] SPU_RBUF_RESET = 8'h00;
  localparam logic SPU_FLAG_RESET = 1'b0;

  // Async receiver states, Gray coded along idle -> start -> bits
  typedef enum logic [1:0]
  {
    SPU_RX_IDLE = 2'h0,
    SPU_RX_START = 2'h1,
    SPU_RX_BITS = 2'h3
  } spu_rx_e;

endpackage : spu_pkg

// [design/spu_serial_port.sv]
`timescale 1ns/1ps
// Behaviour
// - Mode field picks shift, 8-bit or 9-bit UART
// - Timer in modes 1,3; generator in 0,1,3
// - Timer rate from 8-bit auto-reload overflows
// - rate_double doubles timer or generator rate
// - Generator: 8-bit reload, clock direct or /6
// - Generator counts only while brg_run set
// - Mode 0: clock on out pin, data on in pin
// - Mode 0 bytes shift LSB first
// - Buffer write starts mode 0 send, D0 first
// - Mode 0 send ends: pin high, transmit flag
// - Mode 0 receive: eight samples, then receive flag
// - Mode 0 rate fixed clk/6 or generator/16
// - Mode 1 frame: start, eight data, stop
// - Mode 1 stop bit stored as rx ninth bit
// - Modes 2,3 frame: start, eight, ninth, stop
// - Ninth bit sent from tx, stored to rx
// - Async send starts on buffer write
// - Async receive starts on falling in pin
// - Framing check flags missing stop bit
// - Framing error sticky until software clear
// - Checking moves receive flag to stop bit
// - Mode 2 rate clk/32, or /16 doubled
// - Separate rate sources for receive and send
module spu_serial_port
  import spu_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MODE_SELECT_HI,
  input wire logic MODE_SELECT_LO,
  input wire logic RECEIVE_ENABLE,
  input wire logic TX_NINTH_BIT,
  input wire logic RATE_DOUBLE,
  input wire logic FRAMING_CHECK_ENABLE,
  input wire logic BRG_RUN,
  input wire logic BRG_PRESCALE_BYPASS,
  input wire logic [7:0] BRG_RELOAD_VALUE,
  input wire logic RX_RATE_SOURCE,
  input wire logic TX_RATE_SOURCE,
  input wire logic SHIFT_MODE_RATE_SELECT,
  input wire logic TIMER_OVERFLOW,
  input wire logic SERIAL_BUFFER_WRITE,
  input wire logic [7:0] SERIAL_BUFFER_WDATA,
  input wire logic TRANSMIT_DONE_CLEAR,
  input wire logic RECEIVE_DONE_CLEAR,
  input wire logic FRAMING_ERROR_CLEAR,
  output logic [7:0] SERIAL_BUFFER_RDATA,
  output logic TRANSMIT_DONE_FLAG,
  output logic RECEIVE_DONE_FLAG,
  output logic RX_NINTH_BIT,
  output logic FRAMING_ERROR_FLAG,
  output logic SERIAL_IRQ,
  output logic SERIAL_OUT_PIN,
  input wire logic SERIAL_IN_PIN_I,
  output logic SERIAL_IN_PIN_O,
  output logic SERIAL_IN_PIN_OE
);
  import spu_pkg::*;

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    logic [2:0] brg_pre; // Divide-by-6 prescaler
    logic [7:0] brg_cnt; // Auto-reload baud counter
    logic tx_half; // Halves the tx rate source when not doubled
    logic rx_half; // Halves the rx rate source when not doubled
    logic busy; // Transmitter busy, or mode 0 transfer busy
    logic m0_rx; // Mode 0 transfer is a reception
    logic m0_low; // Mode 0 shift clock in its low half
    logic [2:0] m0_div; // Mode 0 half-bit divider
    logic [3:0] tx_sub; // Tx oversample count
    logic [3:0] tx_cnt; // Bits sent so far
    logic [10:0] tx_shift; // Outgoing frame, LSB on the line
    spu_rx_e rx_state; // Async receiver state
    logic [3:0] rx_sub; // Rx oversample count
    logic [3:0] rx_cnt; // Samples taken after the start bit
    logic [8:0] rx_shift; // Incoming bits, entering at the top
    logic rx_prev; // Last sampled line level for edge detect
    logic [7:0] rbuf; // Receive buffer read through SERIAL_BUFFER_RDATA
    logic rb8; // Received ninth or stop bit
    logic ti; // Transmit done
    logic ri; // Receive done
    logic fe; // Framing error
  } spu_state_s;

  spu_state_s st; // Registered state
  spu_state_s next_st; // Next state

  // ========================================================================
  // Decoded controls
  // ========================================================================
  logic [1:0] mode; // Mode field
  logic mode0; // Shift register mode
  logic mode23; // Nine data bit modes
  logic brg_en; // Generator advances this clock
  logic brg_ovf; // Generator overflow pulse
  logic tx_src; // Raw tx rate source pulse
  logic rx_src; // Raw rx rate source pulse
  logic tx_tick; // Tx oversample tick
  logic rx_tick; // Rx oversample tick
  logic m0_src; // Mode 0 rate source pulse
  logic m0_tick; // Mode 0 half-bit boundary
  logic [2:0] m0_half_last; // Mode 0 half length
  logic [8:0] rx_next_shift; // Rx shift with the current sample in

  assign mode = {MODE_SELECT_HI, MODE_SELECT_LO};
  assign mode0 = (mode == SPU_MODE_SHIFT);
  assign mode23 = (mode == SPU_MODE_UART9_FIXED) || (mode == SPU_MODE_UART9_VAR);

  // Generator clocked directly or through the /6 prescaler, only when run
  assign brg_en = BRG_RUN
    && (BRG_PRESCALE_BYPASS || (st.brg_pre == SPU_BRG_PRESCALE_LAST));
  assign brg_ovf = brg_en && (st.brg_cnt == SPU_BRG_TOP);

  // Mode 2 runs off the clock; modes 1 and 3 pick timer or generator
  // separately per direction. Source select 1 = generator, 0 = timer.
  always_comb
  begin
    if (mode == SPU_MODE_UART9_FIXED)
    begin
      tx_src = 1'b1;
      rx_src = 1'b1;
    end
    else
    begin
      tx_src = TX_RATE_SOURCE ? brg_ovf : TIMER_OVERFLOW;
      rx_src = RX_RATE_SOURCE ? brg_ovf : TIMER_OVERFLOW;
    end
  end

  // 16 ticks per bit; without doubling every second source pulse counts
  assign tx_tick = tx_src && (RATE_DOUBLE || st.tx_half);
  assign rx_tick = rx_src && (RATE_DOUBLE || st.rx_half);

  // Mode 0 has no doubling; only the generator can make its variable rate
  assign m0_src = SHIFT_MODE_RATE_SELECT ? brg_ovf : 1'b1;
  assign m0_half_last = SHIFT_MODE_RATE_SELECT ? SPU_M0_VAR_HALF_LAST
                                               : SPU_M0_FIXED_HALF_LAST;
  assign m0_tick = m0_src && (st.m0_div == m0_half_last);

  assign rx_next_shift = {SERIAL_IN_PIN_I, st.rx_shift[8:1]};

  // ========================================================================
  // Next-state logic
  // ========================================================================
  // Flags are cleared first and set afterwards so a same-cycle event wins
  always_comb
  begin
    next_st = st;
    next_st.rx_prev = SERIAL_IN_PIN_I;

    // Software clears of the sticky flags
    if (TRANSMIT_DONE_CLEAR)
      next_st.ti = 1'b0;
    if (RECEIVE_DONE_CLEAR)
      next_st.ri = 1'b0;
    if (FRAMING_ERROR_CLEAR)
      next_st.fe = 1'b0;

    // Baud generator
    if (BRG_RUN && !BRG_PRESCALE_BYPASS)
      next_st.brg_pre = (st.brg_pre == SPU_BRG_PRESCALE_LAST) ? 3'h0
                                                             : st.brg_pre + 3'h1;
    if (brg_en)
      next_st.brg_cnt = brg_ovf ? BRG_RELOAD_VALUE : st.brg_cnt + 8'h01;
    if (tx_src)
      next_st.tx_half = !st.tx_half;
    if (rx_src)
      next_st.rx_half = !st.rx_half;

    // Transfer starts; a buffer write while busy is ignored
    if (!st.busy && SERIAL_BUFFER_WRITE)
    begin
      next_st.busy = 1'b1;
      next_st.m0_rx = 1'b0;
      next_st.m0_low = 1'b0;
      next_st.m0_div = 3'h0;
      next_st.tx_sub = 4'h0;
      next_st.tx_cnt = 4'h0;
      if (mode0)
        next_st.tx_shift = {3'h7, SERIAL_BUFFER_WDATA};
      else if (mode23)
        next_st.tx_shift = {1'b1, TX_NINTH_BIT, SERIAL_BUFFER_WDATA, 1'b0};
      else
        next_st.tx_shift = {2'h3, SERIAL_BUFFER_WDATA, 1'b0};
    end
    else if (!st.busy && mode0 && RECEIVE_ENABLE && !st.ri)
    begin
      // Held control bits (mode 0, enable set, flag clear) begin a receive
      next_st.busy = 1'b1;
      next_st.m0_rx = 1'b1;
      next_st.m0_low = 1'b0;
      next_st.m0_div = 3'h0;
      next_st.tx_cnt = 4'h0;
    end
    else if (st.busy && mode0)
    begin
      // Mode 0: each bit is a high half then a low half of the clock
      if (m0_src)
        next_st.m0_div = m0_tick ? 3'h0 : st.m0_div + 3'h1;
      if (m0_tick && !st.m0_low)
        next_st.m0_low = 1'b1;
      else if (m0_tick)
      begin
        next_st.m0_low = 1'b0;
        next_st.tx_cnt = st.tx_cnt + 4'h1;
        if (st.m0_rx)
          next_st.rx_shift = rx_next_shift;
        else
          next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
        if (st.tx_cnt == SPU_M0_LAST_BIT)
        begin
          next_st.busy = 1'b0;
          if (st.m0_rx)
          begin
            next_st.rbuf = rx_next_shift[8:1];
            next_st.ri = 1'b1;
          end
          else
            next_st.ti = 1'b1;
        end
      end
    end
    else if (st.busy && tx_tick)
    begin
      // Async transmit, one bit per 16 ticks
      next_st.tx_sub = st.tx_sub + 4'h1;
      if (st.tx_sub == SPU_OVS_LAST)
      begin
        next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
        next_st.tx_cnt = st.tx_cnt + 4'h1;
        if (st.tx_cnt == (mode23 ? SPU_TX_LAST_M23 : SPU_TX_LAST_M1))
        begin
          next_st.busy = 1'b0;
          next_st.ti = 1'b1;
        end
      end
    end

    // Async receiver
    unique case (st.rx_state)
      SPU_RX_IDLE:
      begin
        // Falling edge on the input line starts a frame
        if (!mode0 && RECEIVE_ENABLE && st.rx_prev && !SERIAL_IN_PIN_I)
        begin
          next_st.rx_state = SPU_RX_START;
          next_st.rx_sub = 4'h0;
        end
      end
      SPU_RX_START:
      begin
        // Mid-bit recheck rejects glitches shorter than half a bit
        if (rx_tick)
        begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          if (st.rx_sub == SPU_OVS_MID)
          begin
            next_st.rx_state = SERIAL_IN_PIN_I ? SPU_RX_IDLE : SPU_RX_BITS;
            next_st.rx_sub = 4'h0;
            next_st.rx_cnt = 4'h0;
          end
        end
      end
      SPU_RX_BITS:
      begin
        if (rx_tick)
        begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          if (st.rx_sub == SPU_OVS_LAST)
          begin
            next_st.rx_cnt = st.rx_cnt + 4'h1;
            if (st.rx_cnt <= SPU_RX_NINTH_IDX)
              next_st.rx_shift = rx_next_shift;
            // Mode 1 ends on its stop bit; modes 2/3 end on the ninth bit,
            // or on the stop bit when framing is checked
            if ((st.rx_cnt == SPU_RX_STOP23_IDX)
                || ((st.rx_cnt == SPU_RX_NINTH_IDX) && !(mode23 && FRAMING_CHECK_ENABLE)))
            begin
              next_st.rx_state = SPU_RX_IDLE;
              if (FRAMING_CHECK_ENABLE && !SERIAL_IN_PIN_I
                  && (!mode23 || (st.rx_cnt == SPU_RX_STOP23_IDX)))
                next_st.fe = 1'b1;
              // A frame landing on an unread buffer is dropped
              if (!st.ri)
              begin
                next_st.ri = 1'b1;
                if (st.rx_cnt == SPU_RX_STOP23_IDX)
                begin
                  next_st.rbuf = st.rx_shift[7:0];
                  next_st.rb8 = st.rx_shift[8];
                end
                else
                begin
                  next_st.rbuf = rx_next_shift[7:0];
                  next_st.rb8 = rx_next_shift[8];
                end
              end
            end
          end
        end
      end
      default:
        next_st.rx_state = SPU_RX_IDLE;
    endcase
  end

  // ========================================================================
  // State register
  // ========================================================================
  // Synchronous reset; all control state has a known value
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st <= '0;
      st.tx_shift <= '1;
      st.rx_prev <= 1'b1;
      st.rx_state <= SPU_RX_IDLE;
      st.rbuf <= SPU_RBUF_RESET;
      st.ti <= SPU_FLAG_RESET;
      st.ri <= SPU_FLAG_RESET;
      st.fe <= SPU_FLAG_RESET;
    end
    else
      st <= next_st;
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign SERIAL_BUFFER_RDATA = st.rbuf;
  assign TRANSMIT_DONE_FLAG = st.ti;
  assign RECEIVE_DONE_FLAG = st.ri;
  assign RX_NINTH_BIT = st.rb8;
  assign FRAMING_ERROR_FLAG = st.fe;
  assign SERIAL_IRQ = st.ti || st.ri;

  // Out pin: shift clock in mode 0 (idle high), async line otherwise
  assign SERIAL_OUT_PIN = mode0 ? !(st.busy && st.m0_low)
                                : (!st.busy || st.tx_shift[0]);
  // In pin: driven in mode 0 except while receiving; high when idle
  assign SERIAL_IN_PIN_OE = mode0 && !(st.busy && st.m0_rx);
  assign SERIAL_IN_PIN_O = !(st.busy && !st.m0_rx) || st.tx_shift[0];

endmodule : spu_serial_port

// [sim/spu_partner.sv]
`timescale 1ns/1ps
// ==========================================
// Far side: shift expander or remote sender
// ==========================================
module spu_partner
(
  input wire logic clk,
  input wire logic shift_clk,
  input wire logic dev_oe,
  output logic line
);
  logic [7:0] byte_q; // Byte the expander shifts out
  logic [2:0] idx; // Bit now on the wire
  logic shift_en = 1'b0; // Expander owns the line
  logic last_clk = 1'b1; // Shift clock one edge ago
  logic async_q = 1'b1; // Sender level, idle high
  // Next bit only after the rising shift clock, so the device sampled first
  always @(posedge clk)
  begin
    last_clk <= shift_clk;
    // Parked expander rewinds, so a later load starts at bit 0
    if (!shift_en)
      idx <= 3'h0;
    else if (!dev_oe && !last_clk && shift_clk)
      idx <= idx + 3'h1;
  end
  assign line = shift_en ? byte_q[idx] : async_q;
  // Arm or park the expander
  task load(input logic [7:0] b, input logic en);
    byte_q = b;
    shift_en = en;
  endtask : load
  // One frame, bit 0 first; the start bit makes the falling edge
  task send(input logic [10:0] bits, input int n, input int cpb);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      async_q <= bits[i];
      repeat (cpb - 1) @(posedge clk);
    end
    @(posedge clk);
    async_q <= 1'b1;
  endtask : send
endmodule : spu_partner

// [sim/spu_serial_port_checker.sv]
`timescale 1ns/1ps
// ==================================
// Port checker for the serial port
// ==================================
module spu_checker
  import spu_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MODE_SELECT_HI,
  input wire logic MODE_SELECT_LO,
  input wire logic SHIFT_MODE_RATE_SELECT,
  input wire logic FRAMING_CHECK_ENABLE,
  input wire logic TRANSMIT_DONE_CLEAR,
  input wire logic RECEIVE_DONE_CLEAR,
  input wire logic FRAMING_ERROR_CLEAR,
  input wire logic [7:0] SERIAL_BUFFER_RDATA,
  input wire logic TRANSMIT_DONE_FLAG,
  input wire logic RECEIVE_DONE_FLAG,
  input wire logic FRAMING_ERROR_FLAG,
  input wire logic SERIAL_IRQ,
  input wire logic SERIAL_OUT_PIN,
  input wire logic SERIAL_IN_PIN_O
);
  logic m0; // Shift mode selected
  assign m0 = ({MODE_SELECT_HI, MODE_SELECT_LO} == SPU_MODE_SHIFT);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_irq; SERIAL_IRQ == (TRANSMIT_DONE_FLAG | RECEIVE_DONE_FLAG); endproperty
  a_irq: assert property (p_irq) else $error("irq not the or of flags");
  property p_ti; TRANSMIT_DONE_FLAG && !TRANSMIT_DONE_CLEAR |=> TRANSMIT_DONE_FLAG; endproperty
  a_ti: assert property (p_ti) else $error("transmit flag dropped");
  property p_ri; RECEIVE_DONE_FLAG && !RECEIVE_DONE_CLEAR |=> RECEIVE_DONE_FLAG; endproperty
  a_ri: assert property (p_ri) else $error("receive flag dropped");
  property p_fe; FRAMING_ERROR_FLAG && !FRAMING_ERROR_CLEAR |=> FRAMING_ERROR_FLAG; endproperty
  a_fe: assert property (p_fe) else $error("framing flag dropped");
  property p_fe_cause; $rose(FRAMING_ERROR_FLAG) |-> $past(FRAMING_CHECK_ENABLE); endproperty
  a_fe_cause: assert property (p_fe_cause) else $error("framing flag unasked");
  // Fixed shift rate: low half is three clocks, then high again
  property p_half;
    $fell(SERIAL_OUT_PIN) && m0 && !SHIFT_MODE_RATE_SELECT
      |-> !SERIAL_OUT_PIN[*3] ##1 SERIAL_OUT_PIN;
  endproperty
  a_half: assert property (p_half) else $error("shift clock half wrong");
  property p_end;
    $rose(TRANSMIT_DONE_FLAG) |-> SERIAL_OUT_PIN && (!m0 || SERIAL_IN_PIN_O);
  endproperty
  a_end: assert property (p_end) else $error("pins not high at end");
  // Buffer frozen while an old byte is unread
  property p_hold;
    RECEIVE_DONE_FLAG && $past(RECEIVE_DONE_FLAG) |-> $stable(SERIAL_BUFFER_RDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer overwritten");
endmodule : spu_checker
bind spu_serial_port spu_checker chk (.CLK, .RST_N, .MODE_SELECT_HI, .MODE_SELECT_LO,
  .SHIFT_MODE_RATE_SELECT, .FRAMING_CHECK_ENABLE, .TRANSMIT_DONE_CLEAR, .RECEIVE_DONE_CLEAR,
  .FRAMING_ERROR_CLEAR, .SERIAL_BUFFER_RDATA, .TRANSMIT_DONE_FLAG, .RECEIVE_DONE_FLAG,
  .FRAMING_ERROR_FLAG, .SERIAL_IRQ, .SERIAL_OUT_PIN, .SERIAL_IN_PIN_O);

// [sim/spu_serial_port_bench.sv]
`timescale 1ns/1ps
// ==============================
// Bench for the serial port
// ==============================
module spu_serial_port_bench;
  import spu_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ren = 1'b0, tb8 = 1'b0, dbl = 1'b0, fce = 1'b0;
  logic run = 1'b1, byp = 1'b1, rx_src = 1'b1, tx_src = 1'b1, m0sel = 1'b0, tovf = 1'b0;
  logic wr = 1'b0, clr_t = 1'b0, clr_r = 1'b0, clr_f = 1'b0;
  logic [1:0] mode = 2'h0, tdiv = 2'h0; // Mode code, timer divider
  logic [7:0] reload = 8'hff, wdata = 8'h00, rdata;
  logic ti, ri, rb8, fe, irq, txd, pin_o, pin_oe, pline;
  wire logic pin = pin_oe ? pin_o : pline; // Resolved data pin
  int errors = 0, samples_checked = 0;
  always #10 clk = ~clk;
  // Timer stand-in: overflow pulse every 4 clocks
  always @(posedge clk)
  begin
    tdiv <= tdiv + 2'h1;
    tovf <= (tdiv == 2'h3);
  end
  spu_serial_port dut (.CLK(clk), .RST_N(rst_n), .MODE_SELECT_HI(mode[1]),
    .MODE_SELECT_LO(mode[0]), .RECEIVE_ENABLE(ren), .TX_NINTH_BIT(tb8), .RATE_DOUBLE(dbl),
    .FRAMING_CHECK_ENABLE(fce), .BRG_RUN(run), .BRG_PRESCALE_BYPASS(byp),
    .BRG_RELOAD_VALUE(reload), .RX_RATE_SOURCE(rx_src), .TX_RATE_SOURCE(tx_src),
    .SHIFT_MODE_RATE_SELECT(m0sel), .TIMER_OVERFLOW(tovf), .SERIAL_BUFFER_WRITE(wr),
    .SERIAL_BUFFER_WDATA(wdata), .TRANSMIT_DONE_CLEAR(clr_t), .RECEIVE_DONE_CLEAR(clr_r),
    .FRAMING_ERROR_CLEAR(clr_f), .SERIAL_BUFFER_RDATA(rdata), .TRANSMIT_DONE_FLAG(ti),
    .RECEIVE_DONE_FLAG(ri), .RX_NINTH_BIT(rb8), .FRAMING_ERROR_FLAG(fe), .SERIAL_IRQ(irq),
    .SERIAL_OUT_PIN(txd), .SERIAL_IN_PIN_I(pin), .SERIAL_IN_PIN_O(pin_o),
    .SERIAL_IN_PIN_OE(pin_oe));
  spu_partner far (.clk(clk), .shift_clk(txd), .dev_oe(pin_oe), .line(pline));
  // Verdict and end of run
  task print_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // One comparison
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait: 0 transmit flag, 1 receive flag, 2 falling out pin
  task wait_ev(input int sel, output int n);
    logic last;
    logic hit;
    last = txd;
    hit = 1'b0;
    n = 0;
    while (!hit)
    begin
      @(posedge clk);
      n++;
      hit = (sel == 0) ? (ti === 1'b1) : (sel == 1) ? (ri === 1'b1) : (last && txd === 1'b0);
      last = txd;
      if (n > 5000)
      begin
        errors++;
        print_verdict();
      end
    end
  endtask : wait_ev
  // Buffer write pulse
  task put(input logic [7:0] d);
    @(posedge clk);
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : put
  // Clear pulse, mask is {fe, ri, ti}
  task clr(input logic [2:0] m);
    @(posedge clk);
    {clr_f, clr_r, clr_t} <= m;
    @(posedge clk);
    {clr_f, clr_r, clr_t} <= 3'h0;
  endtask : clr
  // Rate setup; one spare edge lets the generator pick it up
  task cfg(input logic [7:0] rl, input logic bp, input logic ts, input logic rs);
    reload <= rl;
    byp <= bp;
    tx_src <= ts;
    rx_src <= rs;
    @(posedge clk);
  endtask : cfg
  // Mode 0 send: data bit seen at each falling shift clock
  task t_m0_tx(input logic [7:0] d, input logic sel, input int cpb);
    int n;
    m0sel <= sel;
    put(d);
    for (int k = 0; k < 8; k++)
    begin
      wait_ev(2, n);
      check(pin_o, d[k]);
      if (k > 0)
        check(n, cpb);
    end
    wait_ev(0, n);
    check({pin_o, pin_oe, txd}, 3'h7);
    clr(3'h1);
  endtask : t_m0_tx
  // Mode 0 receive from the expander
  task t_m0_rx(input logic [7:0] d);
    int n;
    far.load(d, 1'b1);
    ren <= 1'b1;
    // Data pin released while the expander drives it
    repeat (2) @(posedge clk);
    check(pin_oe, 1'b0);
    wait_ev(1, n);
    // Reception over: the device owns the idle data pin again
    check({rdata, irq, pin_oe}, {d, 2'h3});
    ren <= 1'b0;
    far.load(8'h00, 1'b0);
    clr(3'h2);
  endtask : t_m0_rx
  // Async send: each frame bit sampled mid-bit on the out pin
  task t_atx(input logic [1:0] m, input logic db, input logic [7:0] d, input logic nine,
    input int cpb);
    logic [10:0] f;
    int n;
    f = {1'b1, (m == 2'h1) | nine, d, 1'b0};
    mode <= m;
    dbl <= db;
    tb8 <= nine;
    put(d);
    wait_ev(2, n);
    repeat (cpb / 2 - 1) @(posedge clk);
    for (int k = 0; k < ((m == 2'h1) ? 10 : 11); k++)
    begin
      check(txd, f[k]);
      repeat (cpb) @(posedge clk);
    end
    wait_ev(0, n);
    clr(3'h1);
  endtask : t_atx
  // Async receive; ex is {byte, ninth, framing} expected afterwards
  task t_arx(input logic [1:0] m, input logic db, input int cpb, input logic [7:0] d,
    input logic nine, input logic stop, input logic fc, input logic [9:0] ex);
    logic [10:0] f;
    logic was;
    f = (m == 2'h1) ? {1'b1, stop, d, 1'b0} : {stop, nine, d, 1'b0};
    was = ri;
    mode <= m;
    dbl <= db;
    fce <= fc;
    ren <= 1'b1;
    @(posedge clk);
    fork
      far.send(f, (m == 2'h1) ? 10 : 11, cpb);
      begin
        repeat (10 * cpb + cpb / 4) @(posedge clk);
        if (m != 2'h1 && !was)
          check(ri, !fc);
      end
    join
    repeat (cpb) @(posedge clk);
    check({ri, rdata, rb8, fe}, {1'b1, ex});
  endtask : t_arx
  // Frozen generator holds the frame until it runs again
  task t_run();
    int n;
    run <= 1'b0;
    put(8'h55);
    repeat (300) @(posedge clk);
    check(ti, 1'b0);
    run <= 1'b1;
    wait_ev(0, n);
    clr(3'h1);
  endtask : t_run
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({ti, ri, fe, rb8, irq, rdata}, {5'h00, SPU_RBUF_RESET});
    check({txd, pin_o, pin_oe}, 3'h7);
    t_m0_tx(8'hb4, 1'b0, 6);
    t_m0_tx(8'h2d, 1'b1, 16);
    t_m0_rx(8'h1d);
    cfg(8'hfe, 1'b1, 1'b1, 1'b1);
    t_atx(2'h2, 1'b0, 8'h35, 1'b1, 32);
    t_atx(2'h2, 1'b1, 8'hca, 1'b0, 16);
    t_atx(2'h1, 1'b1, 8'h69, 1'b0, 32);
    cfg(8'hfe, 1'b0, 1'b1, 1'b1);
    t_atx(2'h1, 1'b1, 8'h0f, 1'b0, 192);
    cfg(8'hfe, 1'b1, 1'b0, 1'b1);
    t_atx(2'h3, 1'b0, 8'h81, 1'b1, 128);
    cfg(8'hfe, 1'b1, 1'b1, 1'b1);
    t_arx(2'h1, 1'b1, 32, 8'h96, 1'b0, 1'b1, 1'b0, {8'h96, 2'h2});
    clr(3'h2);
    cfg(8'hfe, 1'b1, 1'b1, 1'b0);
    t_arx(2'h3, 1'b0, 128, 8'h5a, 1'b1, 1'b0, 1'b1, {8'h5a, 2'h3});
    clr(3'h2);
    t_arx(2'h2, 1'b1, 16, 8'hc3, 1'b0, 1'b1, 1'b1, {8'hc3, 2'h1});
    t_arx(2'h2, 1'b1, 16, 8'h11, 1'b1, 1'b1, 1'b0, {8'hc3, 2'h1});
    clr(3'h6);
    // The clear lands on the edge clr returns at; look one edge later
    @(posedge clk);
    check(fe, 1'b0);
    t_arx(2'h2, 1'b0, 32, 8'h11, 1'b1, 1'b1, 1'b0, {8'h11, 2'h2});
    clr(3'h2);
    mode <= 2'h1;
    t_run();
    print_verdict();
  end
endmodule : spu_serial_port_bench
